// [pcs_cfg.svh]
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// System clock and the trimmed slow timebase derived from it
`define PCS_CLK_HZ          40000000
`define PCS_SLOW_HZ         32768
`define PCS_DIV_CYC         (`PCS_CLK_HZ / `PCS_SLOW_HZ)
`define PCS_DIV_W           11

// Start-up timing in microseconds and in trimmed slow ticks (rounded up)
`define PCS_RST_DLY_US      2000
`define PCS_RST_DLY_TICKS   ((`PCS_RST_DLY_US * `PCS_SLOW_HZ + 999999) / 1000000)
`define PCS_SEQ_STEP_US     30
`define PCS_SEQ_STEP_TICKS  ((`PCS_SEQ_STEP_US * `PCS_SLOW_HZ + 999999) / 1000000)
`define PCS_TCNT_W          7

// Debounce length in untrimmed slow ticks
`define PCS_DEB_TICKS       2
`define PCS_DEB_W           3

// Regulator slots and fault inputs
`define PCS_N_SLOTS         5
`define PCS_SLOT_W          3
`define PCS_N_FAULTS        4

// Synchroniser bit positions
`define PCS_SYNC_W          9
`define PCS_SY_PWR          0
`define PCS_SY_VIN          1
`define PCS_SY_UCLK         2
`define PCS_SY_VSEL         3
`define PCS_SY_IOV          4
`define PCS_SY_FLT          5

// Interrupt status / mask layout
`define PCS_IRQ_W           6
`define PCS_IRQ_POWER_ON_REQUEST       0
`define PCS_IRQ_LOWIN       1
`define PCS_IRQ_FLT         2
`define PCS_MASK_RST        6'h00

// Register offsets
`define PCS_ADDR_W          8
`define PCS_OFF_STATUS      8'h00
`define PCS_OFF_MASK        8'h04
`define PCS_OFF_SENSE       8'h08
`define PCS_OFF_MODE        8'h0c

// Sense register bits
`define PCS_SNS_POWER_ON_REQUEST       0
`define PCS_SNS_VIN         1
`define PCS_SNS_LOWRNG      2
`define PCS_SNS_IOV         3

`endif

// [pcs_pkg.sv]
`include "pcs_cfg.svh"

package pcs_pkg;

   // Power mode, one-hot
   typedef enum logic [3:0] {
      pcs_st_off      = 4'b0001,
      pcs_st_seq      = 4'b0010,
      pcs_st_rst_wait = 4'b0100,
      pcs_st_on       = 4'b1000
   } pcs_mode_t;

   // Register port request
   typedef struct packed {
      logic [`PCS_ADDR_W-1:0] addr;
      logic [31:0]            wdata;
      logic                   wr;
      logic                   rd;
   } pcs_bus_req_t;

   // Debounced level with its stability counter
   typedef struct packed {
      logic                  level;
      logic [`PCS_DEB_W-1:0] cnt;
   } pcs_deb_t;

   // Two-stage synchroniser state
   typedef struct packed {
      logic [`PCS_SYNC_W-1:0] meta;
      logic [`PCS_SYNC_W-1:0] stab;
   } pcs_sync_t;

   // Whole state of the control block
   typedef struct packed {
      pcs_mode_t                 mode;
      logic [`PCS_DIV_W-1:0]     div_cnt;
      logic [`PCS_TCNT_W-1:0]    tick_cnt;
      logic [`PCS_SLOT_W-1:0]    slot;
      logic [`PCS_N_SLOTS-1:0]   reg_en;
      logic                      uclk_prev;
      pcs_deb_t                  pwr;
      pcs_deb_t                  vin;
      logic [`PCS_N_FAULTS-1:0]  flt_prev;
      logic [`PCS_IRQ_W-1:0]     status;
      logic [`PCS_IRQ_W-1:0]     mask;
      logic                      irq_oe;
      logic                      rst_oe;
      logic                      low_range;
      logic [31:0]               rdata;
   } pcs_state_t;

endpackage

// [pcs_sync.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"

// Two flip-flop synchroniser for all asynchronous pins
module pcs_sync
   import pcs_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   input  wire logic [`PCS_SYNC_W-1:0] async_in,
   output logic      [`PCS_SYNC_W-1:0] sync_out
);

   pcs_sync_t sy_q;
   pcs_sync_t sy_d;

   // First stage feeds only the second stage
   always_comb begin
      sy_d.meta = async_in;
      sy_d.stab = sy_q.meta;
   end

   // Both stages clear under reset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sy_q <= '0;
      end else begin
         sy_q <= sy_d;
      end
   end

   assign sync_out = sy_q.stab;

endmodule

// [pcs_control.sv]
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_control
   import pcs_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   input  wire pcs_bus_req_t             bus_req_in,
   output logic      [31:0]              bus_rdata_out,
   input  wire logic                     power_on_request_in,
   input  wire logic                     vin_above_threshold_in,
   input  wire logic                     slow_clk_untrimmed_in,
   input  wire logic                     card_voltage_select_in,
   input  wire logic                     io_supply_valid_in,
   input  wire logic [`PCS_N_FAULTS-1:0] fault_in,
   output logic      [`PCS_N_SLOTS-1:0]  regulator_enable_out,
   output logic                          card_supply_low_range_out,
   output logic                          processor_reset_d_out,
   output logic                          processor_reset_oe_out,
   output logic                          fault_interrupt_n_d_out,
   output logic                          fault_interrupt_n_oe_out,
   output logic                          irq_out
);

   pcs_state_t             st_q;
   pcs_state_t             st_d;
   logic [`PCS_SYNC_W-1:0] pins_async;
   logic [`PCS_SYNC_W-1:0] pins;
   logic                   ttick;
   logic                   utick;
   logic                   turn_on;
   logic                   turn_off;
   logic                   pwr_rise;
   logic                   vin_fall;
   logic                   vsel_eff;
   logic [`PCS_N_FAULTS-1:0] flt_now;
   logic [`PCS_IRQ_W-1:0]  irq_set;
   logic [`PCS_IRQ_W-1:0]  irq_clr;

   // One debounce step: level flips after a stable run of untrimmed ticks
   function automatic pcs_deb_t deb_step(input pcs_deb_t cur, input logic raw,
                                         input logic tick);
      pcs_deb_t nxt;
      nxt = cur;
      if (raw == cur.level) begin
         nxt.cnt = '0;
      end else if (tick) begin
         if (cur.cnt == `PCS_DEB_W'(`PCS_DEB_TICKS - 1)) begin
            nxt.level = raw;
            nxt.cnt   = '0;
         end else begin
            nxt.cnt = cur.cnt + `PCS_DEB_W'(1);
         end
      end
      return nxt;
   endfunction

   // Pin gathering for the synchroniser
   assign pins_async = {fault_in, io_supply_valid_in, card_voltage_select_in,
                        slow_clk_untrimmed_in, vin_above_threshold_in,
                        power_on_request_in};

   pcs_sync u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (pins_async),
      .sync_out (pins)
   );

   // Next-state logic
   always_comb begin
      st_d = st_q;

      ttick = (st_q.div_cnt == `PCS_DIV_W'(`PCS_DIV_CYC - 1));
      st_d.div_cnt = ttick ? '0 : st_q.div_cnt + `PCS_DIV_W'(1);

      utick = pins[`PCS_SY_UCLK] & ~st_q.uclk_prev;
      st_d.uclk_prev = pins[`PCS_SY_UCLK];
      st_d.pwr = deb_step(st_q.pwr, pins[`PCS_SY_PWR], utick);
      st_d.vin = deb_step(st_q.vin, pins[`PCS_SY_VIN], utick);

      // Events from debounced levels
      pwr_rise = st_d.pwr.level & ~st_q.pwr.level;
      vin_fall = ~st_d.vin.level & st_q.vin.level;
      turn_on  = 1'b0;
      turn_off = ~st_q.pwr.level | ~st_q.vin.level;

      // Fault edges
      flt_now = pins[`PCS_SY_FLT +: `PCS_N_FAULTS];
      st_d.flt_prev = flt_now;

      // Power mode sequencer
      case (st_q.mode)
         pcs_st_off: begin
            st_d.reg_en   = '0;
            st_d.rst_oe   = 1'b1;
            st_d.tick_cnt = '0;
            if (st_q.pwr.level & st_q.vin.level) begin
               turn_on       = 1'b1;
               st_d.mode     = pcs_st_seq;
               st_d.reg_en   = `PCS_N_SLOTS'(1);
               st_d.slot     = `PCS_SLOT_W'(1);
            end
         end
         pcs_st_seq: begin
            if (turn_off) begin
               st_d.mode   = pcs_st_off;
               st_d.reg_en = '0;
            end else if (ttick) begin
               if (st_q.tick_cnt == `PCS_TCNT_W'(`PCS_SEQ_STEP_TICKS - 1)) begin
                  st_d.tick_cnt          = '0;
                  st_d.reg_en[st_q.slot] = 1'b1;
                  if (st_q.slot == `PCS_SLOT_W'(`PCS_N_SLOTS - 1)) begin
                     st_d.mode = pcs_st_rst_wait;
                  end else begin
                     st_d.slot = st_q.slot + `PCS_SLOT_W'(1);
                  end
               end else begin
                  st_d.tick_cnt = st_q.tick_cnt + `PCS_TCNT_W'(1);
               end
            end
         end
         pcs_st_rst_wait: begin
            if (turn_off) begin
               st_d.mode   = pcs_st_off;
               st_d.reg_en = '0;
            end else if (ttick) begin
               if (st_q.tick_cnt == `PCS_TCNT_W'(`PCS_RST_DLY_TICKS - 1)) begin
                  st_d.tick_cnt = '0;
                  st_d.rst_oe   = 1'b0;
                  st_d.mode     = pcs_st_on;
               end else begin
                  st_d.tick_cnt = st_q.tick_cnt + `PCS_TCNT_W'(1);
               end
            end
         end
         pcs_st_on: begin
            if (turn_off) begin
               st_d.mode   = pcs_st_off;
               st_d.reg_en = '0;
               st_d.rst_oe = 1'b1;
            end
         end
         default: begin
            st_d.mode   = pcs_st_off;
            st_d.reg_en = '0;
            st_d.rst_oe = 1'b1;
         end
      endcase

      // invalid I/O supply forces select high
      vsel_eff = pins[`PCS_SY_VSEL] | ~pins[`PCS_SY_IOV];
      st_d.low_range = vsel_eff;

      // Interrupt sources
      irq_set = '0;
      irq_set[`PCS_IRQ_POWER_ON_REQUEST] = turn_on | (pwr_rise & st_d.vin.level);
      irq_set[`PCS_IRQ_LOWIN] = vin_fall;
      irq_set[`PCS_IRQ_FLT +: `PCS_N_FAULTS] = flt_now & ~st_q.flt_prev;

      // Register writes and clearing reads
      irq_clr    = '0;
      st_d.rdata = '0;
      if (bus_req_in.wr) begin
         if (bus_req_in.addr == `PCS_OFF_STATUS) begin
            irq_clr = bus_req_in.wdata[`PCS_IRQ_W-1:0];
         end else if (bus_req_in.addr == `PCS_OFF_MASK) begin
            st_d.mask = bus_req_in.wdata[`PCS_IRQ_W-1:0];
         end
      end else if (bus_req_in.rd) begin
         if (bus_req_in.addr == `PCS_OFF_STATUS) begin
            st_d.rdata[`PCS_IRQ_W-1:0] = st_q.status;
            irq_clr = st_q.status;
         end else if (bus_req_in.addr == `PCS_OFF_MASK) begin
            st_d.rdata[`PCS_IRQ_W-1:0] = st_q.mask;
         end else if (bus_req_in.addr == `PCS_OFF_SENSE) begin
            st_d.rdata[`PCS_SNS_POWER_ON_REQUEST]  = st_q.pwr.level;
            st_d.rdata[`PCS_SNS_VIN]    = st_q.vin.level;
            st_d.rdata[`PCS_SNS_LOWRNG] = st_q.low_range;
            st_d.rdata[`PCS_SNS_IOV]    = pins[`PCS_SY_IOV];
         end else if (bus_req_in.addr == `PCS_OFF_MODE) begin
            st_d.rdata[3:0] = st_q.mode;
            st_d.rdata[8:4] = st_q.reg_en;
         end
      end

      // sticky bits, a new event beats the clear
      st_d.status = (st_q.status & ~irq_clr) | irq_set;

      // pull low on any unmasked pending bit
      st_d.irq_oe = |(st_d.status & ~st_d.mask);
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q           <= '0;
         st_q.mode      <= pcs_st_off;
         st_q.rst_oe    <= 1'b1;
         st_q.low_range <= 1'b1;
         st_q.mask      <= `PCS_MASK_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // reset and interrupt pins open-drain, low level only, enable drives; other outputs driven directly
   assign processor_reset_d_out    = 1'b0;
   assign processor_reset_oe_out   = st_q.rst_oe;
   assign fault_interrupt_n_d_out  = 1'b0;
   assign fault_interrupt_n_oe_out = st_q.irq_oe;
   assign irq_out                  = st_q.irq_oe;
   assign regulator_enable_out     = st_q.reg_en;
   assign card_supply_low_range_out = st_q.low_range;
   assign bus_rdata_out            = st_q.rdata;

endmodule

// [pcs_control_assertions.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"

// Port-level checks of the power control block
module pcs_control_chk
   import pcs_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   input  wire pcs_bus_req_t             bus_req_in,
   input  wire logic [31:0]              bus_rdata_out,
   input  wire logic                     card_voltage_select_in,
   input  wire logic                     io_supply_valid_in,
   input  wire logic [`PCS_N_FAULTS-1:0] fault_in,
   input  wire logic [`PCS_N_SLOTS-1:0]  regulator_enable_out,
   input  wire logic                     card_supply_low_range_out,
   input  wire logic                     processor_reset_d_out,
   input  wire logic                     processor_reset_oe_out,
   input  wire logic                     fault_interrupt_n_d_out,
   input  wire logic                     fault_interrupt_n_oe_out,
   input  wire logic                     irq_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   logic [19:0] since_q;

   // Cycles since the last start-up slot came on
   always_ff @(posedge clk_in) begin
      if (reset_in || !regulator_enable_out[4]) begin
         since_q <= 20'h0;
      end else begin
         since_q <= since_q + 20'h1;
      end
   end

   a_od_data_low: assert property (!processor_reset_d_out && !fault_interrupt_n_d_out)
      else $error("open-drain data not low");
   a_irq_pin_same: assert property (irq_out == fault_interrupt_n_oe_out)
      else $error("irq level and pin differ");
   a_rst_needs_all: assert property (!processor_reset_oe_out |-> regulator_enable_out == 5'h1f)
      else $error("reset released before all slots on");
   a_rst_when_off: assert property (regulator_enable_out == 5'h00 |-> processor_reset_oe_out)
      else $error("reset not asserted while off");
   a_rst_delay_ok: assert property ($fell(processor_reset_oe_out) |-> since_q >= 20'h13880 && since_q <= 20'h13f4c)
      else $error("reset release delay wrong");
   a_w1c_release: assert property (bus_req_in.wr && bus_req_in.addr == 8'h00
      && bus_req_in.wdata[5:0] == 6'h3f && fault_in == $past(fault_in, 3) |=> !irq_out)
      else $error("interrupt held after clearing write");
   a_mask_gates: assert property (bus_req_in.wr && bus_req_in.addr == 8'h04
      && bus_req_in.wdata[5:0] == 6'h3f |=> !irq_out)
      else $error("interrupt with all masked");
   // Read data only after a read
   a_rdata_idle: assert property (!$past(bus_req_in.rd) |-> bus_rdata_out == 32'h0)
      else $error("read data outside read slot");
   a_range_low: assert property ((io_supply_valid_in && card_voltage_select_in) [*5]
      |-> card_supply_low_range_out)
      else $error("select high not lower range");
   a_range_high: assert property ((io_supply_valid_in && !card_voltage_select_in) [*5]
      |-> !card_supply_low_range_out)
      else $error("select low not higher range");
   a_range_noio: assert property ((!io_supply_valid_in) [*5] |-> card_supply_low_range_out)
      else $error("no io supply not lower range");
endmodule

bind pcs_control pcs_control_chk u_chk (
   .clk_in(clk_in), .reset_in(reset_in), .bus_req_in(bus_req_in),
   .bus_rdata_out(bus_rdata_out), .card_voltage_select_in(card_voltage_select_in),
   .io_supply_valid_in(io_supply_valid_in), .fault_in(fault_in),
   .regulator_enable_out(regulator_enable_out),
   .card_supply_low_range_out(card_supply_low_range_out),
   .processor_reset_d_out(processor_reset_d_out),
   .processor_reset_oe_out(processor_reset_oe_out),
   .fault_interrupt_n_d_out(fault_interrupt_n_d_out),
   .fault_interrupt_n_oe_out(fault_interrupt_n_oe_out), .irq_out(irq_out)
);

// [pcs_host_model.sv]
`timescale 1ns/1ps

// Host processor inputs with pull-ups on both open-drain lines
module pcs_host_model (
   input  wire logic rst_d_in,
   input  wire logic rst_oe_in,
   input  wire logic int_d_in,
   input  wire logic int_oe_in,
   output logic      rst_pin_out,
   output logic      int_pin_out
);
   assign rst_pin_out = rst_oe_in ? rst_d_in : 1'b1;
   assign int_pin_out = int_oe_in ? int_d_in : 1'b1;
endmodule

// [pcs_testbench.sv]
`timescale 1ns/1ps

module testbench;
   import pcs_pkg::*;
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] msk;
   } pcs_note_t;

   logic         clk_in, reset_in, pwr, vin, uclk, vsel, iov, rd_q;
   logic         low_rng, rst_d, rst_oe, int_d, int_oe, irq, rst_pin, int_pin;
   logic [3:0]   flt, n_slow;
   logic [4:0]   en;
   logic [31:0]  rdata;
   pcs_bus_req_t req;
   pcs_note_t    notes[$];
   pcs_note_t    nt;
   int           n_mismatch, compares, seed, i, n;

   // Clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // Untrimmed slow clock, sped up to one rise per 16 cycles
   always @(posedge clk_in) begin
      n_slow <= n_slow + 4'h1;
      uclk <= n_slow[3];
      rd_q <= req.rd;
   end

   pcs_control dut (
      .clk_in(clk_in), .reset_in(reset_in), .bus_req_in(req), .bus_rdata_out(rdata),
      .power_on_request_in(pwr), .vin_above_threshold_in(vin), .slow_clk_untrimmed_in(uclk),
      .card_voltage_select_in(vsel), .io_supply_valid_in(iov), .fault_in(flt),
      .regulator_enable_out(en), .card_supply_low_range_out(low_rng),
      .processor_reset_d_out(rst_d), .processor_reset_oe_out(rst_oe),
      .fault_interrupt_n_d_out(int_d), .fault_interrupt_n_oe_out(int_oe), .irq_out(irq)
   );
   pcs_host_model host (
      .rst_d_in(rst_d), .rst_oe_in(rst_oe), .int_d_in(int_d), .int_oe_in(int_oe),
      .rst_pin_out(rst_pin), .int_pin_out(int_pin)
   );

   task automatic fail(input string m);
      n_mismatch++;
      $display("FAIL %0t %s", $time, m);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         fail(m);
      end
   endtask

   task automatic final_report;
      $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic tmo(input int lim);
      if (n >= lim) begin
         fail("wait ran out");
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      req <= '0;
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{exp: e, msk: m});
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      req <= '0;
      @(posedge clk_in);
   endtask

   // Read word against the oldest note, in the slot after the strobe
   always @(negedge clk_in) begin
      if (rd_q === 1'b1) begin
         if (notes.size() == 0) begin
            fail("read without note");
         end else begin
            nt = notes.pop_front();
            chk(rdata & nt.msk, nt.exp, "read data");
         end
      end
   end

   initial begin
      seed = 97822;
      n_mismatch = 0;
      compares = 0;
      {reset_in, pwr, vin, vsel, iov, flt, n_slow, uclk, req} = '0;
      reset_in = 1'b1;
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      chk(32'(rst_pin), 32'h0, "reset pin after reset");
      rd(8'h04, 32'h0, 32'hffffffff);
      rd(8'h00, 32'h0, 32'hffffffff);
      rd(8'h0c, 32'h1, 32'hffffffff);
      rd(8'h10, 32'h0, 32'hffffffff);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         {iov, vsel} <= i[1:0];
         repeat (6) @(posedge clk_in);
         chk(32'(low_rng), 32'(i != 2), "card range");
      end
      $display("test card range done");
      i = $unsigned($random(seed)) % 4;
      flt <= 4'h1 << i;
      repeat (4) @(posedge clk_in);
      flt <= 4'h0;
      repeat (6) @(posedge clk_in);
      chk(32'(int_pin), 32'h0, "fault pin");
      rd(8'h00, 32'h4 << i, 32'h3c);
      @(posedge clk_in);
      chk(32'(int_pin), 32'h1, "pin after read");
      flt <= 4'h8;
      repeat (8) @(posedge clk_in);
      wr(8'h00, 32'h3f);
      chk(32'(int_pin), 32'h1, "pin after clear");
      wr(8'h04, 32'h3f);
      flt <= 4'h2;
      repeat (8) @(posedge clk_in);
      chk(32'(int_pin), 32'h1, "masked fault");
      wr(8'h04, 32'h0);
      chk(32'(int_pin), 32'h0, "unmasked pending");
      flt <= 4'h0;
      wr(8'h00, 32'h3f);
      $display("test faults done");
      {vin, pwr} <= 2'b11;
      for (n = 0; n < 4000 && en !== 5'h01; n++) @(posedge clk_in);
      tmo(4000);
      rd(8'h08, 32'hf, 32'hf);
      rd(8'h00, 32'h1, 32'h1);
      chk(32'(rst_pin), 32'h0, "reset during start-up");
      for (n = 0; n < 90000 && rst_pin !== 1'b1; n++) @(posedge clk_in);
      tmo(90000);
      chk(32'(n >= 84177 && n <= 85396), 32'h1, "release time");
      chk(32'(en), 32'h1f, "all slots on");
      $display("test start-up done");
      pwr <= 1'b0;
      for (n = 0; n < 4000 && rst_pin !== 1'b0; n++) @(posedge clk_in);
      tmo(4000);
      @(posedge clk_in);
      chk(32'(en), 32'h0, "slots off");
      $display("test turn-off done");
      final_report();
   end
endmodule
